// file: core/pcrs_regs.vh
// Notes on behaviour
// - Peripheral rate bits matter only while the core double-speed bit is set.
// - In double-speed mode, peripheral bit clear gives 6 periods, set gives 12.
// - UART rate bit applies only to serial modes 0 and 2.
// - Core bit clear: CPU and all peripherals use 12 periods per cycle.
// - Core bit set: CPU uses 6 periods, peripheral bits become active.
// - After power-up the core bit loads from the security configuration byte.
// - Core register resets to zero above bit 0; bit 0 from security byte.
// - SPI register at AFh holds the SPI rate bit in bit 0.
// - SPI rate bit resets to zero; reserved bits always read back as zero.
// - Core bit changes take effect only on rising edge of oscillator divided by two.
// - Core register at 8Fh: bit 0 core, bits 4..1 UART, timer2, timer1, timer0.
`ifndef PCRS_REGS_VH
`define PCRS_REGS_VH
// ----------------------------------------
// Register addresses
// ----------------------------------------
`define PCRS_CORE_ADDR      8'h8F
`define PCRS_SPI_ADDR       8'hAF
// ----------------------------------------
// Field positions
// ----------------------------------------
`define PCRS_BIT_CORE       0
`define PCRS_BIT_TIMER0     1
`define PCRS_BIT_TIMER1     2
`define PCRS_BIT_TIMER2     3
`define PCRS_BIT_UART       4
`define PCRS_BIT_SPI        0
`define PCRS_CORE_MASK      8'h1F
`define PCRS_SPI_MASK       8'h01
// ----------------------------------------
// Reset values and timing
// ----------------------------------------
`define PCRS_CORE_RST       8'h00
`define PCRS_SPI_RST        8'h00
`define PCRS_PER_SLOW       4'hC
`define PCRS_PER_FAST       4'h6
`define PCRS_PH_MAX         4'hB
`endif

// file: core/pcrs_rate_div.v
`timescale 1ns/1ps
`include "pcrs_regs.vh"
// Free-running divider: one-cycle tick every 6 or 12 oscillator clocks
module pcrs_rate_div (
  input  wire       mclk,      // oscillator clock
  input  wire       reset,     // async reset, active high
  input  wire       fast,      // 1: 6 periods, 0: 12 periods
  output reg        tick       // one pulse per peripheral cycle
);
  reg [3:0] cnt_reg;
  wire [3:0] last = fast ? (`PCRS_PER_FAST - 4'h1) : `PCRS_PH_MAX;

  // Wrap at or above the end so a switch to fast mid-count cannot overrun
  always @(posedge mclk or posedge reset)
  begin
    if (reset)
    begin
      cnt_reg <= 4'h0;
      tick    <= 1'b0;
    end
    else if (cnt_reg >= last)
    begin
      cnt_reg <= 4'h0;
      tick    <= 1'b1;
    end
    else
    begin
      cnt_reg <= cnt_reg + 4'h1;
      tick    <= 1'b0;
    end
  end
endmodule // pcrs_rate_div

// file: core/pcrs_clock_select.v
`timescale 1ns/1ps
`include "pcrs_regs.vh"
module pcrs_clock_select (
  input  wire       mclk,               // oscillator clock
  input  wire       reset,              // async reset, active high
  input  wire [7:0] sfr_addr,           // special-function address
  input  wire [7:0] sfr_wdata,          // write data
  input  wire       sfr_wr,             // write strobe
  input  wire       sfr_rd,             // read strobe
  input  wire [1:0] uart_mode,          // serial port mode
  input  wire       security_config_byte, // core bit of security byte
  output reg  [7:0] sfr_rdata,          // read data, registered
  output reg        sfr_rd_hit,         // read addressed this block
  output reg        double_speed_core,  // applied core bit
  output reg        cpu_tick,           // machine-cycle pulse
  output reg        timer0_tick,        // timer 0 cycle pulse
  output reg        timer1_tick,        // timer 1 cycle pulse
  output reg        timer2_tick,        // timer 2 cycle pulse
  output reg        uart_tick,          // UART cycle pulse
  output reg        spi_tick            // SPI cycle pulse
);
  reg  [4:0] core_clock_rate_control_reg;
  reg        spi_clock_rate_control_reg;
  reg        strap_done_reg;
  reg        half_reg;
  wire       req_core = core_clock_rate_control_reg[`PCRS_BIT_CORE];

  // ----------------------------------------
  // Local constants
  // ----------------------------------------
  // Full-width copies, so the narrow fields are cut on purpose
  localparam [7:0] CORE_RST_FULL   = `PCRS_CORE_RST;
  localparam [7:0] SPI_RST_FULL    = `PCRS_SPI_RST;
  localparam [4:0] CORE_RST        = CORE_RST_FULL[4:0];
  localparam [0:0] SPI_RST         = SPI_RST_FULL[`PCRS_BIT_SPI];
  localparam [1:0] UART_SYNC_MODE  = 2'h0;
  localparam [1:0] UART_FIXED_MODE = 2'h2;

  // ----------------------------------------
  // Address and mode decode
  // ----------------------------------------
  // Shared by the write and read paths so the map cannot drift apart
  function is_core_addr;
    input [7:0] addr;
    begin
      is_core_addr = (addr == `PCRS_CORE_ADDR);
    end
  endfunction

  function is_spi_addr;
    input [7:0] addr;
    begin
      is_spi_addr = (addr == `PCRS_SPI_ADDR);
    end
  endfunction

  function uart_bit_valid;
    input [1:0] mode;
    begin
      uart_bit_valid = (mode == UART_SYNC_MODE) || (mode == UART_FIXED_MODE);
    end
  endfunction

  // ----------------------------------------
  // Access strobes
  // ----------------------------------------
  // Decoded once; the strap edge still overrides a core write
  wire       wr_core = sfr_wr & is_core_addr(sfr_addr);
  wire       wr_spi  = sfr_wr & is_spi_addr(sfr_addr);
  wire       rd_core = sfr_rd & is_core_addr(sfr_addr);
  wire       rd_spi  = sfr_rd & is_spi_addr(sfr_addr);

  // ----------------------------------------
  // Field taps
  // ----------------------------------------
  // Named once, so the decode below reads by peripheral, not by bit
  wire       t0_sel  = core_clock_rate_control_reg[`PCRS_BIT_TIMER0];
  wire       t1_sel  = core_clock_rate_control_reg[`PCRS_BIT_TIMER1];
  wire       t2_sel  = core_clock_rate_control_reg[`PCRS_BIT_TIMER2];
  wire       ua_sel  = core_clock_rate_control_reg[`PCRS_BIT_UART];
  wire       sp_sel  = spi_clock_rate_control_reg;

  // ----------------------------------------
  // Per-peripheral speed decode
  // ----------------------------------------
  function fast_sel;
    input core;
    input sel;
    begin
      fast_sel = core & ~sel;
    end
  endfunction

  wire cpu_fast = double_speed_core;
  wire t0_fast  = fast_sel(double_speed_core, t0_sel);
  wire t1_fast  = fast_sel(double_speed_core, t1_sel);
  wire t2_fast  = fast_sel(double_speed_core, t2_sel);
  // Modes 1 and 3 follow the core rate only
  wire uart_m02 = uart_bit_valid(uart_mode);
  wire u_fast   = uart_m02 ? fast_sel(double_speed_core, ua_sel) : double_speed_core;
  wire s_fast   = fast_sel(double_speed_core, sp_sel);

  // ----------------------------------------
  // Register file
  // ----------------------------------------
  // Strap caught by the clock after release, never by the reset itself
  always @(posedge mclk or posedge reset)
  begin
    if (reset)
      strap_done_reg <= 1'h0;
    else
      strap_done_reg <= 1'h1;
  end

  // Strap edge wins over a write; that write is dropped, not deferred
  always @(posedge mclk or posedge reset)
  begin
    if (reset)
      core_clock_rate_control_reg <= CORE_RST;
    else if (!strap_done_reg)
      core_clock_rate_control_reg[`PCRS_BIT_CORE] <= security_config_byte;
    else if (wr_core)
      core_clock_rate_control_reg <= sfr_wdata[4:0];
  end

  always @(posedge mclk or posedge reset)
  begin
    if (reset)
      spi_clock_rate_control_reg <= SPI_RST;
    else if (wr_spi)
      spi_clock_rate_control_reg <= sfr_wdata[`PCRS_BIT_SPI];
  end

  // ----------------------------------------
  // Read path
  // ----------------------------------------
  reg  [7:0] rdata_next;
  reg        rd_hit_next;

  // Reserved bits masked, so they read back as zero whatever was written
  always @*
  begin
    rdata_next  = 8'h00;
    rd_hit_next = 1'h0;
    if (rd_core)
    begin
      rdata_next  = {3'h0, core_clock_rate_control_reg} & `PCRS_CORE_MASK;
      rd_hit_next = 1'h1;
    end
    else if (rd_spi)
    begin
      rdata_next  = {7'h00, spi_clock_rate_control_reg} & `PCRS_SPI_MASK;
      rd_hit_next = 1'h1;
    end
  end

  // Data stands for one cycle, then falls back to zero
  always @(posedge mclk or posedge reset)
  begin
    if (reset)
    begin
      sfr_rdata  <= 8'h00;
      sfr_rd_hit <= 1'h0;
    end
    else
    begin
      sfr_rdata  <= rdata_next;
      sfr_rd_hit <= rd_hit_next;
    end
  end

  // ----------------------------------------
  // Glitch-free core switch
  // ----------------------------------------
  // Phase flop marks the rising edge of the half-rate clock
  always @(posedge mclk or posedge reset)
  begin
    if (reset)
      half_reg <= 1'h0;
    else
      half_reg <= ~half_reg;
  end

  wire       apply_edge = ~half_reg;

  // Switching only there keeps a half-rate period from being cut short
  always @(posedge mclk or posedge reset)
  begin
    if (reset)
      double_speed_core <= 1'h0;
    else if (apply_edge)
      double_speed_core <= req_core;
  end

  // ----------------------------------------
  // Dividers
  // ----------------------------------------
  wire cpu_w;
  wire t0_w;
  wire t1_w;
  wire t2_w;
  wire u_w;
  wire s_w;

  // One divider per consumer, so each switches rate on its own count
  pcrs_rate_div u_cpu
  (
    .mclk  (mclk),
    .reset (reset),
    .fast  (cpu_fast),
    .tick  (cpu_w)
  );

  pcrs_rate_div u_t0
  (
    .mclk  (mclk),
    .reset (reset),
    .fast  (t0_fast),
    .tick  (t0_w)
  );

  pcrs_rate_div u_t1
  (
    .mclk  (mclk),
    .reset (reset),
    .fast  (t1_fast),
    .tick  (t1_w)
  );

  pcrs_rate_div u_t2
  (
    .mclk  (mclk),
    .reset (reset),
    .fast  (t2_fast),
    .tick  (t2_w)
  );

  pcrs_rate_div u_ua
  (
    .mclk  (mclk),
    .reset (reset),
    .fast  (u_fast),
    .tick  (u_w)
  );

  pcrs_rate_div u_spi
  (
    .mclk  (mclk),
    .reset (reset),
    .fast  (s_fast),
    .tick  (s_w)
  );

  // ----------------------------------------
  // Output flops
  // ----------------------------------------
  // Each pulse leaves its own flop, so no consumer sees a decode glitch
  always @(posedge mclk or posedge reset)
  begin
    if (reset)
      cpu_tick <= 1'h0;
    else
      cpu_tick <= cpu_w;
  end

  always @(posedge mclk or posedge reset)
  begin
    if (reset)
      timer0_tick <= 1'h0;
    else
      timer0_tick <= t0_w;
  end

  always @(posedge mclk or posedge reset)
  begin
    if (reset)
      timer1_tick <= 1'h0;
    else
      timer1_tick <= t1_w;
  end

  always @(posedge mclk or posedge reset)
  begin
    if (reset)
      timer2_tick <= 1'h0;
    else
      timer2_tick <= t2_w;
  end

  always @(posedge mclk or posedge reset)
  begin
    if (reset)
      uart_tick <= 1'h0;
    else
      uart_tick <= u_w;
  end

  always @(posedge mclk or posedge reset)
  begin
    if (reset)
      spi_tick <= 1'h0;
    else
      spi_tick <= s_w;
  end
endmodule // pcrs_clock_select

// file: test/pcrs_chk_asserts.sv
`timescale 1ns/1ps
module pcrs_chk (
  input wire       mclk,              // clock
  input wire       reset,             // reset
  input wire [7:0] sfr_addr,          // address
  input wire       sfr_rd,            // read
  input wire [7:0] sfr_rdata,         // data
  input wire       sfr_rd_hit,        // hit
  input wire       double_speed_core, // core bit
  input wire       cpu_tick,          // cpu
  input wire       timer0_tick        // timer 0
);
  wire ds = double_speed_core;
  default clocking @(posedge mclk); endclocking
  default disable iff (reset);
  property p_rd_core; sfr_rd && sfr_addr == 8'h8F |=> sfr_rd_hit && sfr_rdata[7:5] == 3'h0; endproperty
  a_rd_core: assert property (p_rd_core) else $error("core read");
  property p_rd_spi; sfr_rd && sfr_addr == 8'hAF |=> sfr_rd_hit && sfr_rdata[7:1] == 7'h00; endproperty
  a_rd_spi: assert property (p_rd_spi) else $error("spi read");
  property p_miss; sfr_rd && sfr_addr != 8'h8F && sfr_addr != 8'hAF |=> !sfr_rd_hit && sfr_rdata == 8'h00; endproperty
  a_miss: assert property (p_miss) else $error("unmapped read");
  property p_idle; !sfr_rd |=> !sfr_rd_hit && sfr_rdata == 8'h00; endproperty
  a_idle: assert property (p_idle) else $error("idle read data");
  // Dividers restart after a pulse, so no gap is ever below six
  property p_gap; cpu_tick |=> !cpu_tick [*5]; endproperty
  a_gap: assert property (p_gap) else $error("cpu gap");
  property p_fast; cpu_tick && ds ##1 ds [*6] |-> cpu_tick; endproperty
  a_fast: assert property (p_fast) else $error("cpu fast");
  property p_slow; cpu_tick && !ds ##1 !ds [*8] ##1 !ds [*4] |-> cpu_tick; endproperty
  a_slow: assert property (p_slow) else $error("cpu slow");
  property p_t0; timer0_tick && !ds ##1 !ds [*8] ##1 !ds [*4] |-> timer0_tick; endproperty
  a_t0: assert property (p_t0) else $error("timer0 slow");
endmodule // pcrs_chk
bind pcrs_clock_select pcrs_chk u_chk (.mclk, .reset, .sfr_addr, .sfr_rd, .sfr_rdata, .sfr_rd_hit,
  .double_speed_core, .cpu_tick, .timer0_tick);

// file: test/tb_top.sv
`timescale 1ns/1ps
module tb_top;
  reg        mclk, reset, sfr_wr, sfr_rd, strap;
  reg  [7:0] sfr_addr, sfr_wdata;
  reg  [1:0] uart_mode;
  reg [31:0] v;
  wire [7:0] sfr_rdata;
  wire       sfr_rd_hit, dsc;
  wire [5:0] tk;
  integer    errors, n_tests, cyc, seed, core_m, spi_m, i, j, k;
  pcrs_clock_select dut (.mclk(mclk), .reset(reset), .sfr_addr(sfr_addr), .sfr_wdata(sfr_wdata), .sfr_wr(sfr_wr),
    .sfr_rd(sfr_rd), .uart_mode(uart_mode), .security_config_byte(strap), .sfr_rdata(sfr_rdata),
    .sfr_rd_hit(sfr_rd_hit), .double_speed_core(dsc), .cpu_tick(tk[0]), .timer0_tick(tk[1]),
    .timer1_tick(tk[2]), .timer2_tick(tk[3]), .uart_tick(tk[4]), .spi_tick(tk[5]));
  task close_out;
  begin
    $display("errors=%0d checks=%0d", errors, n_tests);
    if (errors == 0 && n_tests > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  end
  endtask
  task chk(input [8:0] got, input [8:0] exp);
  begin
    n_tests = n_tests + 1;
    if (got !== exp)
    begin
      errors = errors + 1;
      $display("CHECK FAILED %0t got %h exp %h", $time, got, exp);
    end
  end
  endtask
  task acc(input w, input [7:0] a, input [7:0] d);
  begin
    @(negedge mclk);
    sfr_addr = a;
    sfr_wdata = d;
    sfr_wr = w;
    sfr_rd = !w;
    @(negedge mclk);
    sfr_wr = 1'b0;
    sfr_rd = 1'b0;
    if (!w)
      chk({sfr_rd_hit, sfr_rdata}, {a == 8'h8F || a == 8'hAF, d});
  end
  endtask
  task rst(input b);
  begin
    @(negedge mclk);
    reset = 1'b1;
    strap = b;
    repeat (12) @(negedge mclk);
    reset = 1'b0;
    core_m = b;
    spi_m = 0;
    repeat (2) @(negedge mclk);
  end
  endtask
  // Model: peripheral bit only counts while the core bit is set
  function integer rate(input integer n);
    rate = (core_m[0] && !(n == 5 ? spi_m[0] : n == 4 ? core_m[4] && !uart_mode[0] : n > 0 && core_m[n])) ? 6 : 12;
  endfunction
  task per(input integer n);
  begin
    repeat (14) @(negedge mclk);
    for (k = 0; k < 30 && tk[n] !== 1'b1; k = k + 1)
      @(negedge mclk);
    @(negedge mclk);
    for (k = 1; k < 30 && tk[n] !== 1'b1; k = k + 1)
      @(negedge mclk);
    chk(k[8:0], rate(n));
  end
  endtask
  initial
  begin
    mclk = 1'b0;
    forever #10 mclk = ~mclk;
  end
  always @(posedge mclk)
  begin
    cyc = cyc + 1;
    if (cyc == 20000)
    begin
      errors = errors + 1;
      close_out;
    end
  end
  initial
  begin
    {reset, sfr_wr, sfr_rd, strap, sfr_addr, sfr_wdata, uart_mode} = 0;
    reset = 1'b1;
    {errors, n_tests, cyc} = 0;
    seed = 32'hE2B57E2A;
    rst(1'b1);
    acc(0, 8'h8F, 8'h01);
    acc(0, 8'hAF, 8'h00);
    acc(0, 8'h90, 8'h00);
    for (i = 0; i < 24; i = i + 1)
    begin
      if (i == 12)
      begin
        rst(1'b0);
        acc(0, 8'h8F, 8'h00);
      end
      v = $random(seed);
      uart_mode = v[17:16];
      acc(1, 8'h8F, v[7:0]);
      acc(1, 8'hAF, v[15:8]);
      core_m = v[7:0] & 8'h1F;
      spi_m = v[8];
      acc(0, 8'h8F, core_m[7:0]);
      acc(0, 8'hAF, spi_m[7:0]);
      for (j = 0; j < 6; j = j + 1)
        per(j);
      chk({8'h00, dsc}, {8'h00, core_m[0]});
    end
    close_out;
  end
endmodule // tb_top
